// ===== hdl/ssb_pkg.sv
package ssb_pkg;

    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_PRESCALE = 16'h1f95;
    localparam logic [15:0] IDX_CTRL1    = 16'h1f96;
    localparam logic [15:0] IDX_CTRL2    = 16'h1f97;
    localparam logic [15:0] IDX_STATUS   = 16'h1f97;
    localparam logic [15:0] IDX_BUF0     = 16'h1f98;
    localparam int          BUF_WORDS    = 8;

    // Reset values
    localparam logic [7:0]  CTRL1_RST    = 8'h00;
    localparam logic [4:0]  CTRL2_RST    = 5'h00;
    localparam logic        PRESCALE_RST = 1'b0;

    // Status field positions
    localparam int          STAT_ACTIVE_BIT = 7;
    localparam int          STAT_SHIFT_BIT  = 6;

    // Divider exponents: the slowest code, and the base the other codes count down from
    localparam int          DIV_EXP_SLOW = 13;
    localparam int          DIV_EXP_FAST = 9;
    localparam int          DIV_W        = 15;

    // Transfer modes
    typedef enum logic [2:0] {
        MODE_TX8   = 3'b000,
        MODE_TX4   = 3'b010,
        MODE_TXRX8 = 3'b100,
        MODE_RX8   = 3'b101,
        MODE_RX4   = 3'b110
    } ssb_mode_t;

    // Serial clock select codes
    localparam logic [2:0]  CLK_RSVD = 3'b110;
    localparam logic [2:0]  CLK_EXT  = 3'b111;

    // First control register, bit 7 down to bit 0
    typedef struct packed {
        logic       start;
        logic       abort;
        logic [2:0] mode;
        logic [2:0] clk_sel;
    } ssb_ctrl1_t;

    // Second control register, bits 4 to 0
    typedef struct packed {
        logic [1:0] frame_wait;
        logic [2:0] word_cnt;
    } ssb_ctrl2_t;

    // Engine states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_LOAD  = 3'b001,
        ST_SHIFT = 3'b010,
        ST_GAP   = 3'b011,
        ST_HOLD  = 3'b100
    } ssb_state_t;

    function automatic logic [15:0] byte_addr(input logic [15:0] idx);
        return {idx[13:0], 2'b00};
    endfunction

endpackage

// ===== hdl/ssb_top.sv
`timescale 1ns/1ps
// Contract
// - eight buffer bytes, bursts of up to eight
// - burst end raises the serial burst interrupt
// - 8-bit rx modes stretch frame by wait, internal clock only
// - start bit runs, clearing requests stop
// - abort ends at once, then clears itself
// - mode field decode, other codes reserved
// - clock field selects divider or external pin
// - word count is field plus one
// - 4-bit uses low nibble, zero upper
// - words move lowest address upward
// - word count kept after transfer
// - status bit 7 shows transfer active
// - status bit 6 shows shifting active
// - active flag drops at stop or abort
// - shift out on fall, sample on rise
// - least significant bit first
// - internal clock driven out, paused when behind
module ssb_top (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    // AHB-Lite slave
    input  wire logic        hsel_in,
    input  wire logic [15:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic      [31:0] hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    // Serial pins
    input  wire logic        sck_in,
    output logic             sck_out,
    output logic             sck_oe_out,
    output logic             so_out,
    input  wire logic        si_in,
    // Burst event
    output logic             irq_out
);
    import ssb_pkg::*;

    // Byte address of the lowest buffer byte, kept whole so slices of it are legal
    localparam logic [15:0] BUF_BASE = byte_addr(IDX_BUF0);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    ssb_ctrl1_t     ctrl1_r, ctrl1_nxt;
    ssb_ctrl2_t     ctrl2_r, ctrl2_nxt;
    logic           presc_r, presc_nxt;
    logic           sck_oe_r;
    logic [7:0]     buf_r [BUF_WORDS];
    logic [7:0]     buf_nxt [BUF_WORDS];
    logic           ap_valid_r, ap_write_r;
    logic [15:0]    ap_addr_r;
    logic [31:0]    hrdata_r, hrdata_nxt;
    logic           sck_s1_r, sck_s2_r, sck_s3_r, si_s1_r, si_s2_r;
    logic [DIV_W-1:0] div_r;
    ssb_state_t     st_r, st_nxt;
    logic [2:0]     idx_r, idx_nxt, bit_r, bit_nxt;
    logic [7:0]     sh_r, sh_nxt;
    logic [6:0]     gap_r, gap_nxt;
    logic           sck_r, sck_nxt, so_r, so_nxt, bwait_r, bwait_nxt, irq_r, irq_nxt;
    logic           ext_clk, is4, is_rx, mode_ok, need_gap, half_tick, fall, rise;
    logic           wr_ctrl1, wr_ctrl2, wr_presc, buf_access, abort_clr, store_en, burst_done;
    logic [2:0]     last_bit, wr_idx;
    logic           wr_buf;
    logic [7:0]     store_data;
    logic [DIV_W-1:0] half_mask;

    // Divider exponent per clock code, one power higher with the prescaler
    function automatic int div_exp(input logic [2:0] code, input logic presc);
        int e;
        e = (code == 3'b000) ? DIV_EXP_SLOW : DIV_EXP_FAST - int'(code);
        return e + int'(presc);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Bus decode; zero wait states, so hreadyout stays high
    assign wr_ctrl1 = ap_valid_r && ap_write_r && ap_addr_r == byte_addr(IDX_CTRL1);
    assign wr_ctrl2 = ap_valid_r && ap_write_r && ap_addr_r == byte_addr(IDX_CTRL2);
    assign wr_presc = ap_valid_r && ap_write_r && ap_addr_r == byte_addr(IDX_PRESCALE);
    assign wr_buf   = ap_valid_r && ap_write_r && ap_addr_r[15:5] == BUF_BASE[15:5];
    assign wr_idx   = ap_addr_r[4:2];

    // A buffer read in receive modes, or a buffer write in transmit modes, lifts the pause; unused bytes count too
    always_comb begin
        logic addr_buf;
        addr_buf   = hsel_in && hready_in && htrans_in[1] &&
                     haddr_in[15:5] == BUF_BASE[15:5];
        buf_access = is_rx ? (addr_buf && !hwrite_in) : wr_buf;
        hrdata_nxt = hrdata_r;
        if (hsel_in && hready_in && htrans_in[1] && !hwrite_in) begin
            hrdata_nxt = 32'h0000_0000;
            if (addr_buf) begin
                hrdata_nxt[7:0] = buf_r[haddr_in[4:2]];
            end else if (haddr_in == byte_addr(IDX_STATUS)) begin
                hrdata_nxt[STAT_ACTIVE_BIT] = (st_r != ST_IDLE);
                hrdata_nxt[STAT_SHIFT_BIT]  = (st_r == ST_SHIFT);
            end else if (haddr_in == byte_addr(IDX_PRESCALE)) begin
                hrdata_nxt[0] = presc_r;
            end
        end
    end

    // Address phase capture and read data
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ap_valid_r <= 1'b0;
            ap_write_r <= 1'b0;
            ap_addr_r  <= 16'h0000;
            hrdata_r   <= 32'h0000_0000;
        end else begin
            ap_valid_r <= hsel_in && hready_in && htrans_in[1];
            ap_write_r <= hwrite_in;
            ap_addr_r  <= haddr_in;
            hrdata_r   <= hrdata_nxt;
        end
    end

    assign hrdata_out    = hrdata_r;
    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Control registers; a software write to abort beats the self-clear
    always_comb begin
        ctrl1_nxt = ctrl1_r;
        ctrl2_nxt = ctrl2_r;
        presc_nxt = presc_r;
        if (abort_clr) begin
            ctrl1_nxt.abort = 1'b0;
        end
        if (wr_ctrl1) begin
            ctrl1_nxt = ssb_ctrl1_t'(hwdata_in[7:0]);
        end
        if (wr_ctrl2) begin
            ctrl2_nxt = ssb_ctrl2_t'(hwdata_in[4:0]);
        end
        if (wr_presc) begin
            presc_nxt = hwdata_in[0];
        end
    end

    // Buffer: software writes first, engine store last
    always_comb begin
        for (int i = 0; i < BUF_WORDS; i++) begin
            buf_nxt[i] = buf_r[i];
        end
        if (wr_buf) begin
            buf_nxt[wr_idx] = hwdata_in[7:0];
        end
        if (store_en) begin
            buf_nxt[idx_r] = store_data;
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ctrl1_r <= ssb_ctrl1_t'(CTRL1_RST);
            ctrl2_r <= ssb_ctrl2_t'(CTRL2_RST);
            presc_r <= PRESCALE_RST;
            sck_oe_r <= 1'b1;
            for (int i = 0; i < BUF_WORDS; i++) begin
                buf_r[i] <= 8'h00;
            end
        end else begin
            ctrl1_r <= ctrl1_nxt;
            sck_oe_r <= (ctrl1_nxt.clk_sel != CLK_EXT);
            ctrl2_r <= ctrl2_nxt;
            presc_r <= presc_nxt;
            buf_r   <= buf_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and free-running divider
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sck_s1_r <= 1'b1;
            sck_s2_r <= 1'b1;
            sck_s3_r <= 1'b1;
            si_s1_r  <= 1'b0;
            si_s2_r  <= 1'b0;
            div_r    <= '0;
        end else begin
            sck_s1_r <= sck_in;
            sck_s2_r <= sck_s1_r;
            sck_s3_r <= sck_s2_r;
            si_s1_r  <= si_in;
            si_s2_r  <= si_s1_r;
            div_r    <= div_r + 1'b1;
        end
    end

    // Mode and clock decode
    assign ext_clk   = (ctrl1_r.clk_sel == CLK_EXT);
    assign is4       = (ctrl1_r.mode == MODE_TX4) || (ctrl1_r.mode == MODE_RX4);
    assign is_rx     = (ctrl1_r.mode == MODE_TXRX8) || (ctrl1_r.mode == MODE_RX8) ||
                       (ctrl1_r.mode == MODE_RX4);
    assign mode_ok   = is_rx || (ctrl1_r.mode == MODE_TX8) || is4;
    assign last_bit  = is4 ? 3'd3 : 3'd7;
    assign need_gap  = !ext_clk && ctrl2_r.frame_wait != 2'b00 &&
                       (ctrl1_r.mode == MODE_TXRX8 || ctrl1_r.mode == MODE_RX8);
    assign half_mask = DIV_W'((1 << (div_exp(ctrl1_r.clk_sel, presc_r) - 1)) - 1);
    assign half_tick = ((div_r & half_mask) == half_mask) && ctrl1_r.clk_sel != CLK_RSVD;
    assign fall      = ext_clk ? (sck_s3_r && !sck_s2_r) : (half_tick && sck_r);
    assign rise      = ext_clk ? (!sck_s3_r && sck_s2_r) : (half_tick && !sck_r);
    assign burst_done = st_r == ST_SHIFT && rise && bit_r == last_bit &&
                        idx_r == ctrl2_r.word_cnt;

    ////////////////////////////////////////////////////////////////////////
    // Serial engine
    always_comb begin
        st_nxt     = st_r;
        idx_nxt    = idx_r;
        bit_nxt    = bit_r;
        sh_nxt     = sh_r;
        gap_nxt    = gap_r;
        sck_nxt    = sck_r;
        so_nxt     = so_r;
        irq_nxt    = 1'b0;
        abort_clr  = 1'b0;
        store_en   = 1'b0;
        store_data = 8'h00;
        // Clear first so that a burst ending now still wins
        bwait_nxt  = bwait_r && !buf_access;
        unique case (st_r)
            ST_IDLE: begin
                sck_nxt = 1'b1;
                if (ctrl1_r.abort) begin
                    abort_clr = 1'b1;
                end else if (ctrl1_r.start && mode_ok) begin
                    st_nxt    = ST_LOAD;
                    idx_nxt   = 3'd0;
                    bwait_nxt = 1'b0;
                end
            end
            ST_LOAD: begin
                sh_nxt  = buf_r[idx_r];
                bit_nxt = 3'd0;
                st_nxt  = ST_SHIFT;
            end
            ST_SHIFT: begin
                if (fall) begin
                    so_nxt  = sh_r[0];
                    sck_nxt = ext_clk;
                end else if (rise) begin
                    sck_nxt = 1'b1;
                    sh_nxt  = {si_s2_r, sh_r[7:1]};
                    bit_nxt = bit_r + 3'd1;
                    if (bit_r == last_bit) begin
                        store_en   = is_rx;
                        store_data = is4 ? {4'h0, sh_nxt[7:4]} : sh_nxt;
                        if (idx_r == ctrl2_r.word_cnt) begin
                            irq_nxt   = 1'b1;
                            idx_nxt   = 3'd0;
                            bwait_nxt = 1'b1;
                        end else begin
                            idx_nxt = idx_r + 3'd1;
                        end
                        gap_nxt = 7'((16 << ctrl2_r.frame_wait) - 17);
                        st_nxt  = need_gap ? ST_GAP : ST_HOLD;
                    end
                end
            end
            ST_GAP: begin
                if (half_tick) begin
                    gap_nxt = gap_r - 7'd1;
                    if (gap_r == 7'd0) begin
                        st_nxt = ST_HOLD;
                    end
                end
            end
            ST_HOLD: begin
                if (!ctrl1_r.start) begin
                    st_nxt = ST_IDLE;
                end else if (!bwait_r || ext_clk) begin
                    st_nxt = ST_LOAD;
                end
            end
            default: begin
                st_nxt = ST_IDLE;
            end
        endcase
        if (ctrl1_r.abort && st_r != ST_IDLE) begin
            st_nxt  = ST_IDLE;
            sck_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_r    <= ST_IDLE;
            idx_r   <= 3'd0;
            bit_r   <= 3'd0;
            sh_r    <= 8'h00;
            gap_r   <= 7'd0;
            sck_r   <= 1'b1;
            so_r    <= 1'b1;
            bwait_r <= 1'b0;
            irq_r   <= 1'b0;
        end else begin
            st_r    <= st_nxt;
            idx_r   <= idx_nxt;
            bit_r   <= bit_nxt;
            sh_r    <= sh_nxt;
            gap_r   <= gap_nxt;
            sck_r   <= sck_nxt;
            so_r    <= so_nxt;
            bwait_r <= bwait_nxt;
            irq_r   <= irq_nxt;
        end
    end

    // Pin drive; the clock pin is an input when the external clock is chosen
    assign sck_out    = sck_r;
    assign sck_oe_out = sck_oe_r;
    assign so_out     = so_r;
    assign irq_out    = irq_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    property p_burst_irq;
        burst_done |=> irq_out && idx_r == 3'd0;
    endproperty
    a_burst_irq: assert property (p_burst_irq) else $error("burst end gave no interrupt");

    property p_abort_stop;
        (ctrl1_r.abort && st_r != ST_IDLE) |=> st_r == ST_IDLE ##1 !ctrl1_r.abort || wr_ctrl1;
    endproperty
    a_abort_stop: assert property (p_abort_stop) else $error("abort did not stop or clear");

    property p_stop_hold;
        (st_r == ST_HOLD && !ctrl1_r.start && !ctrl1_r.abort) |=> st_r == ST_IDLE;
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("stop request ignored");

    property p_count_kept;
        !wr_ctrl2 |=> $stable(ctrl2_r.word_cnt);
    endproperty
    a_count_kept: assert property (p_count_kept) else $error("word count changed");

    property p_nibble_zero;
        (store_en && is4) |=> buf_r[$past(idx_r)][7:4] == 4'h0 || $past(wr_buf);
    endproperty
    a_nibble_zero: assert property (p_nibble_zero) else $error("upper nibble not zero");

    property p_idx_up;
        (st_r == ST_SHIFT && rise && bit_r == last_bit && !burst_done && !ctrl1_r.abort)
            |=> idx_r == $past(idx_r) + 3'd1;
    endproperty
    a_idx_up: assert property (p_idx_up) else $error("word index did not advance");

    property p_pause_clock;
        (st_r == ST_HOLD && bwait_r && !ext_clk) |-> sck_out;
    endproperty
    a_pause_clock: assert property (p_pause_clock) else $error("clock ran while paused");

    property p_fall_out;
        (st_r == ST_SHIFT && fall && !ctrl1_r.abort) |=> so_out == $past(sh_r[0]);
    endproperty
    a_fall_out: assert property (p_fall_out) else $error("wrong bit on data out");

    property p_active_flag;
        (hsel_in && hready_in && htrans_in[1] && !hwrite_in &&
         haddr_in == byte_addr(IDX_STATUS))
            |=> hrdata_out[STAT_ACTIVE_BIT] == ($past(st_r) != ST_IDLE);
    endproperty
    a_active_flag: assert property (p_active_flag) else $error("active flag wrong");

endmodule

// ===== tb/ssb_peer.sv
`timescale 1ns/1ps
module ssb_peer (
    // Serial lines
    input  wire logic sck_in,
    input  wire logic so_in,
    output logic      si_out,
    // Bench control
    input  wire logic clr_in,
    input  wire logic nib_in
);
    logic [7:0] tx_mem [8];
    logic [7:0] rx_mem [8];
    realtime    t_start [8];
    int         word_idx;
    int         bit_idx;
    logic [7:0] shreg;

    initial begin
        si_out   = 1'b1;
        word_idx = 0;
        bit_idx  = 0;
    end

    ////////////////////////////////////////
    // Fresh burst: word pointer back to the lowest buffer byte
    always @(posedge clr_in) begin
        word_idx = 0;
        bit_idx  = 0;
    end

    // Next bit goes out on the falling edge, LSB first
    always @(negedge sck_in) begin
        if (bit_idx == 0) begin
            t_start[word_idx % 8] = $realtime;
        end
        si_out = tx_mem[word_idx % 8][bit_idx];
    end

    // Both sides sample on the rising edge; the line is let go after the last bit
    always @(posedge sck_in) begin
        shreg[bit_idx] = so_in;
        bit_idx = bit_idx + 1;
        if (bit_idx == (nib_in ? 4 : 8)) begin
            rx_mem[word_idx % 8] = nib_in ? {4'h0, shreg[3:0]} : shreg;
            word_idx = word_idx + 1;
            bit_idx  = 0;
            // Released line shows the inverse so stale data cannot pass
            si_out   = ~si_out;
        end
    end
endmodule

// ===== tb/ssb_top_tb.sv
`timescale 1ns/1ps
module ssb_top_tb;
    import ssb_pkg::*;
    localparam logic [15:0] A_PRE = IDX_PRESCALE << 2;
    localparam logic [15:0] A_C1  = IDX_CTRL1 << 2;
    localparam logic [15:0] A_C2  = IDX_CTRL2 << 2;
    localparam logic [15:0] A_BUF = IDX_BUF0 << 2;

    logic        clk_in = 1'b0;
    logic        sys_rst_in = 1'b1;
    logic        hsel_in = 1'b0;
    logic [15:0] haddr_in = 16'h0000;
    logic [1:0]  htrans_in = 2'b00;
    logic        hwrite_in = 1'b0;
    logic [2:0]  hsize_in = 3'b010;
    logic [31:0] hwdata_in = 32'h0;
    logic [31:0] hrdata_out;
    logic        hreadyout_out;
    logic        hresp_out;
    logic        sck_in = 1'b1;
    logic        sck_out;
    logic        sck_oe_out;
    logic        so_out;
    logic        si_in;
    logic        irq_out;
    logic        sck_w;
    logic        clr_in = 1'b0;
    logic        nib_in = 1'b0;
    int          err_count = 0;
    int          samples_checked = 0;
    int          irq_cnt = 0;
    logic [31:0] v;

    ////////////////////////////////////////
    // Pin level seen by the peer: the design drives it unless external clock
    assign sck_w = sck_oe_out ? sck_out : sck_in;

    ssb_top dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .hsel_in(hsel_in),
        .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
        .hsize_in(hsize_in), .hwdata_in(hwdata_in), .hready_in(hreadyout_out),
        .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
        .sck_in(sck_in), .sck_out(sck_out), .sck_oe_out(sck_oe_out), .so_out(so_out),
        .si_in(si_in), .irq_out(irq_out));

    ssb_peer peer (.sck_in(sck_w), .so_in(so_out), .si_out(si_in), .clr_in(clr_in),
        .nib_in(nib_in));

    // 10 MHz clock
    initial begin
        forever #50 clk_in = ~clk_in;
    end

    // Burst-end pulses are counted here
    always @(posedge clk_in) begin
        if (irq_out === 1'b1) irq_cnt <= irq_cnt + 1;
    end

    ////////////////////////////////////////
    task automatic end_sim();
        $display("checks=%0d errors=%0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One single AHB transfer; the data phase ends when hready is seen high
    task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge clk_in);
        hsel_in   <= 1'b1;
        htrans_in <= 2'b10;
        haddr_in  <= a;
        hwrite_in <= w;
        do @(posedge clk_in); while (hreadyout_out !== 1'b1);
        hsel_in   <= 1'b0;
        htrans_in <= 2'b00;
        hwdata_in <= wd;
        do @(posedge clk_in); while (hreadyout_out !== 1'b1);
        rd = hrdata_out;
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        bus(1'b1, a, {24'h0, d}, v);
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp, input logic [31:0] m);
        bus(1'b0, a, 32'h0, v);
        chk(v & m, exp);
    endtask

    task automatic wait_irq(input int lim);
        int c0;
        c0 = irq_cnt;
        repeat (lim) begin
            if (irq_cnt == c0) @(posedge clk_in);
        end
        chk(irq_cnt - c0, 1);
    endtask

    // Stop and abort before changing setup, second control only while stopped
    task automatic burst(input logic [2:0] m, input logic [2:0] c, input logic [2:0] n,
                         input logic [1:0] wt);
        wr(A_C1, {2'b01, m, c});
        clr_in <= 1'b1;
        nib_in <= m[1];
        wr(A_C2, {3'b000, wt, n});
        clr_in <= 1'b0;
        wr(A_C1, {2'b10, m, c});
    endtask

    task automatic stop();
        wr(A_C1, 8'h45);
        rd_chk(A_C2, 32'h0, 32'hc0);
    endtask

    function automatic logic [7:0] pat(input int i, input logic [7:0] s);
        return s ^ 8'(i * 37);
    endfunction

    ////////////////////////////////////////
    // Hang guard, well beyond the planned traffic
    initial begin
        #4000000;
        err_count++;
        end_sim();
    end

    // Main sequence
    initial begin
        repeat (3) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        rd_chk(A_C2, 32'h0, 32'hffffffff);
        rd_chk(A_C1, 32'h0, 32'hffffffff);
        rd_chk(16'h0000, 32'h0, 32'hffffffff);
        chk(sck_oe_out, 32'h1);
        wr(A_PRE, 8'h01);
        rd_chk(A_PRE, 32'h1, 32'h1);
        wr(A_PRE, 8'h00);
        for (int i = 0; i < 8; i++) rd_chk(A_BUF + 16'(4 * i), 32'h0, 32'hff);
        for (int i = 0; i < 8; i++) wr(A_BUF + 16'(4 * i), pat(i, 8'h3c));
        for (int i = 0; i < 8; i++) rd_chk(A_BUF + 16'(4 * i), pat(i, 8'h3c), 32'hff);
        $display("reset and buffer test done");

        // Three words out, then the clock must pause until software writes
        burst(MODE_TX8, 3'b101, 3'd2, 2'd0);
        repeat (20) @(posedge clk_in);
        rd_chk(A_C2, 32'hc0, 32'hc0);
        wait_irq(800);
        for (int i = 0; i < 3; i++) chk(peer.rx_mem[i], pat(i, 8'h3c));
        repeat (300) @(posedge clk_in);
        chk(peer.word_idx, 3);
        clr_in <= 1'b1;
        wr(A_BUF, pat(0, 8'h3c));
        clr_in <= 1'b0;
        wait_irq(800);
        chk(peer.word_idx, 3);
        stop();
        $display("transmit test done");

        // Full eight-word receive fills the buffer low to high
        for (int i = 0; i < 8; i++) peer.tx_mem[i] = pat(i, 8'h96);
        burst(MODE_RX8, 3'b101, 3'd7, 2'd0);
        wait_irq(1800);
        for (int i = 0; i < 8; i++) rd_chk(A_BUF + 16'(4 * i), pat(i, 8'h96), 32'hff);
        stop();
        $display("receive test done");

        // Nibble modes: upper half cleared on receive, never sent on transmit
        wr(A_BUF, 8'hff);
        peer.tx_mem[0] = 8'hc9;
        burst(MODE_RX4, 3'b101, 3'd0, 2'd0);
        wait_irq(300);
        rd_chk(A_BUF, 32'h09, 32'hff);
        stop();
        wr(A_BUF, 8'hb6);
        burst(MODE_TX4, 3'b101, 3'd0, 2'd0);
        wait_irq(300);
        chk(peer.rx_mem[0], 8'h06);
        stop();
        $display("nibble test done");

        // Frame stretch in full duplex: word spacing is 2^wait data times
        for (int w = 0; w < 4; w++) begin
            wr(A_BUF, 8'h5c);
            wr(A_BUF + 16'h4, 8'ha3);
            peer.tx_mem[1] = 8'h8e;
            burst(MODE_TXRX8, 3'b101, 3'd1, 2'(w));
            wait_irq(2800);
            v = ((peer.t_start[1] - peer.t_start[0]) >= (1 << w) * 12800.0) &&
                ((peer.t_start[1] - peer.t_start[0]) <= (1 << w) * 12800.0 + 1000.0);
            chk(v, 1);
            chk(peer.rx_mem[1], 8'ha3);
            rd_chk(A_BUF + 16'h4, 32'h8e, 32'hff);
            stop();
        end
        $display("frame wait test done");

        // Reserved mode never starts, reserved clock never ticks
        burst(3'b111, 3'b101, 3'd0, 2'd0);
        repeat (50) @(posedge clk_in);
        rd_chk(A_C2, 32'h0, 32'hc0);
        burst(MODE_TX8, CLK_RSVD, 3'd0, 2'd0);
        repeat (300) @(posedge clk_in);
        chk(peer.word_idx, 0);
        stop();
        wr(A_C1, {2'b01, MODE_TX8, CLK_EXT});
        repeat (2) @(posedge clk_in);
        chk(sck_oe_out, 32'h0);
        $display("reserved code test done");
        end_sim();
    end
endmodule
